// >>> src/core_instruction_execute.sv
`timescale 1ns/10ps
// Operation
// - literal call loads k and latch bits
// - every call pushes counter plus one
// - working call loads working and latch
// - calls take two cycles, flags untouched
// - watchdog clear zeroes counter, sets both
// - sleep zeroes counter, timeout set, powerdown cleared
// - destination zero working, one file register
// - complement file, zero flag only
// - clears write zero and set zero
// - decrement file, zero flag only
// - subtract working and borrow from file
// - literal minus working into working
// - swap nibbles, flags unchanged
module core_instruction_execute
   import core_exec_pkg::*;
#(
   parameter int STACK_DEPTH = 16,
   parameter int FILE_DEPTH = 128,
   parameter int WDOG_W = 8,
   parameter int PRESC_W = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [DATA_W-1:0] pwdata,
   output logic [DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr
);

   // pointer width follows the stack depth
   localparam int SP_W = $clog2(STACK_DEPTH);

   // architectural state
   logic [INSTR_W-1:0] instr_ff;          // last issued instruction
   logic [7:0] work_ff;                   // working register
   logic [LATCH_W-1:0] latch_ff;          // counter_high_latch
   logic carry_ff;                        // carry flag
   logic digit_carry_ff;                  // digit_carry flag
   logic zero_ff;                         // zero flag
   logic timeout_status_ff;               // timeout_status
   logic powerdown_status_ff;             // powerdown_status
   logic [PC_W-1:0] pc_ff;                // program counter
   logic [PC_W-1:0] stack_ff [STACK_DEPTH]; // return stack
   logic [SP_W-1:0] sp_ff;                // next free stack slot
   logic [WDOG_W-1:0] watchdog_counter_ff; // watchdog count
   logic [PRESC_W-1:0] presc_ff;          // watchdog prescaler
   logic [FADDR_W-1:0] faddr_ff;          // file window address
   logic [7:0] file_ff [FILE_DEPTH];      // data register file
   exec_e state_ff;                       // execution sequencer
   logic pready_ff;                       // apb ready
   logic [DATA_W-1:0] prdata_ff;          // apb read data
   logic pslverr_ff;                      // apb error

   // decode of the held instruction
   opcode_e op;                           // current opcode
   logic [FADDR_W-1:0] instr_f;           // file operand
   logic [PC_W-1:0] pc_plus1;             // return address
   logic [SP_W-1:0] sp_top;               // index of stack_top
   logic running;                         // single execute cycle
   logic wdog_clr;                        // watchdog clear request
   logic [DATA_W-1:0] nxt_prdata;         // read mux
   logic addr_hit;                        // mapped address
   logic access;                          // apb access phase
   logic wr_fire;                         // write takes effect
   alu_if alu_bus ();                     // to the operation unit

   assign op = opcode_e'(instr_ff[OPC_LSB +: OPC_W]);
   assign instr_f = instr_ff[FADDR_W-1:0];
   assign pc_plus1 = pc_ff + 15'h0001;
   assign sp_top = sp_ff - SP_W'(1);
   assign running = (state_ff == exec_run);
   assign wdog_clr = running &&
      (op == watchdog_clear_op || op == sleep_op);
   assign access = psel & penable;
   assign wr_fire = access & pwrite & pready_ff;

   // feed the operation unit
   assign alu_bus.op = op;
   assign alu_bus.dest = instr_ff[DEST_BIT];
   assign alu_bus.f_val = file_ff[instr_f];
   assign alu_bus.w_val = work_ff;
   assign alu_bus.lit = instr_ff[7:0];
   assign alu_bus.carry_in = carry_ff;

   core_alu u_alu (
      .bus(alu_bus)
   );

   // apb handshake; access phase waits while an instruction runs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // bus quiet while in reset
         pready_ff <= 1'b0;
         prdata_ff <= WORD_ZERO;
         pslverr_ff <= 1'b0;
      end else if (access && !pready_ff && state_ff == exec_idle) begin
         // one answer per access, writes read zero
         pready_ff <= 1'b1;
         prdata_ff <= pwrite ? WORD_ZERO : nxt_prdata;
         pslverr_ff <= ~addr_hit;
      end else begin
         // ready and error stand one cycle
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
      end
   end

   // read mux and address decode
   always_comb begin
      nxt_prdata = WORD_ZERO;
      addr_hit = 1'b1;
      // narrow fields in the low bits, rest zero
      unique case (paddr)
         OFS_INSTR: nxt_prdata[INSTR_W-1:0] = instr_ff;
         OFS_WORK: nxt_prdata[7:0] = work_ff;
         OFS_LATCH: nxt_prdata[LATCH_W-1:0] = latch_ff;
         OFS_STATUS: begin
            nxt_prdata[ST_C] = carry_ff;
            nxt_prdata[ST_DC] = digit_carry_ff;
            nxt_prdata[ST_Z] = zero_ff;
            nxt_prdata[ST_PD] = powerdown_status_ff;
            nxt_prdata[ST_TO] = timeout_status_ff;
            nxt_prdata[ST_BUSY] = (state_ff != exec_idle);
         end
         OFS_PC: nxt_prdata[PC_W-1:0] = pc_ff;
         OFS_STACK: begin
            nxt_prdata[PC_W-1:0] = stack_ff[sp_top];
            nxt_prdata[STK_PTR_LSB +: SP_W] = sp_ff;
         end
         OFS_WDOG: begin
            nxt_prdata[WDOG_W-1:0] = watchdog_counter_ff;
            nxt_prdata[WD_PRESC_LSB +: PRESC_W] = presc_ff;
         end
         OFS_FADDR: nxt_prdata[FADDR_W-1:0] = faddr_ff;
         OFS_FDATA: nxt_prdata[7:0] = file_ff[faddr_ff];
         default: addr_hit = 1'b0; // unmapped: error, reads zero
      endcase
   end

   // execution sequencer: issue, run, optional second call cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= exec_idle;
         instr_ff <= '0;
      end else begin
         unique case (state_ff)
            exec_idle: begin
               // only an instruction write starts work
               if (wr_fire && paddr == OFS_INSTR) begin
                  instr_ff <= pwdata[INSTR_W-1:0];
                  state_ff <= exec_run;
               end
            end
            exec_run: begin // calls need a second cycle
               // plain operations retire here
               if (op == call_literal_op || op == call_from_working)
                  state_ff <= exec_call_load;
               else
                  state_ff <= exec_idle;
            end
            exec_call_load: state_ff <= exec_idle;
         endcase
      end
   end

   // program counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc_ff <= PC_RST;
      end else if (state_ff == exec_call_load) begin
         // second call cycle: jump to the target
         if (op == call_literal_op) begin
            pc_ff <= {latch_ff[LATCH_HI_LSB +: PC_W-CALL_SPLIT],
                      instr_ff[LIT_W-1:0]};
         end else begin
            pc_ff <= {latch_ff[PC_W-CALL_FROM_WORKING_SPLIT-1:0], work_ff};
         end
      end else if (running && op != call_literal_op &&
                   op != call_from_working) begin
         pc_ff <= pc_plus1; // plain instructions advance by one
      end else if (wr_fire && paddr == OFS_PC) begin
         pc_ff <= pwdata[PC_W-1:0];
      end
   end

   // return stack push in the first call cycle, wraps when full
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sp_ff <= '0;
         // empty stack reads back as zero
         for (int i = 0; i < STACK_DEPTH; i++) begin
            stack_ff[i] <= PC_RST;
         end
      end else if (running && (op == call_literal_op ||
                               op == call_from_working)) begin
         stack_ff[sp_ff] <= pc_plus1;
         sp_ff <= sp_ff + SP_W'(1);
      end
   end

   // working register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         work_ff <= BYTE_ZERO;
      end else if (running && alu_bus.to_w) begin
         // executing instruction outranks software
         work_ff <= alu_bus.result;
      end else if (wr_fire && paddr == OFS_WORK) begin
         work_ff <= pwdata[7:0];
      end
   end

   // data register file and its software window
   // no reset: software fills a register before use
   always_ff @(posedge pclk) begin
      if (running && alu_bus.to_f) begin
         file_ff[instr_f] <= alu_bus.result;
      end else if (wr_fire && paddr == OFS_FDATA) begin
         file_ff[faddr_ff] <= pwdata[7:0];
      end
   end

   // file window address and latch
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         faddr_ff <= '0;
         latch_ff <= '0;
      end else if (wr_fire) begin
         if (paddr == OFS_FADDR)
            faddr_ff <= pwdata[FADDR_W-1:0];
         if (paddr == OFS_LATCH)
            latch_ff <= pwdata[LATCH_W-1:0];
      end
   end

   // arithmetic flags; calls and swap leave them alone
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         carry_ff <= 1'b0;
         digit_carry_ff <= 1'b0;
         zero_ff <= 1'b0;
      end else if (running) begin
         if (alu_bus.upd_z)
            zero_ff <= alu_bus.z_out;
         if (alu_bus.upd_cdc) begin
            carry_ff <= alu_bus.c_out;
            digit_carry_ff <= alu_bus.dc_out;
         end
      end else if (wr_fire && paddr == OFS_STATUS) begin
         // software may preset the flags
         carry_ff <= pwdata[ST_C];
         digit_carry_ff <= pwdata[ST_DC];
         zero_ff <= pwdata[ST_Z];
      end
   end

   // watchdog counter and prescaler
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         watchdog_counter_ff <= '0;
         presc_ff <= '0;
      end else if (wdog_clr) begin
         watchdog_counter_ff <= '0;
         presc_ff <= '0;
      end else begin
         // count steps when the prescaler wraps
         presc_ff <= presc_ff + PRESC_W'(1);
         if (&presc_ff)
            watchdog_counter_ff <= watchdog_counter_ff + WDOG_W'(1);
      end
   end

   // timeout and powerdown status; expiry clears timeout
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timeout_status_ff <= 1'b1;
         powerdown_status_ff <= 1'b1;
      end else if (running && op == watchdog_clear_op) begin
         timeout_status_ff <= 1'b1;
         powerdown_status_ff <= 1'b1;
      end else if (running && op == sleep_op) begin
         timeout_status_ff <= 1'b1;
         powerdown_status_ff <= 1'b0;
      end else if ((&presc_ff) && (&watchdog_counter_ff)) begin
         // expiry: count and prescaler at top
         timeout_status_ff <= 1'b0;
      end
   end

   // outputs straight from flops
   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;

endmodule // core_instruction_execute

// >>> src/core_exec_pkg.sv
package core_exec_pkg;

   // apb geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // register byte offsets
   localparam logic [ADDR_W-1:0] OFS_INSTR = 8'h00;  // instruction issue
   localparam logic [ADDR_W-1:0] OFS_WORK = 8'h04;   // working register
   localparam logic [ADDR_W-1:0] OFS_LATCH = 8'h08;  // counter_high_latch
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h0C; // flags and busy
   localparam logic [ADDR_W-1:0] OFS_PC = 8'h10;     // program counter
   localparam logic [ADDR_W-1:0] OFS_STACK = 8'h14;  // stack_top and depth
   localparam logic [ADDR_W-1:0] OFS_WDOG = 8'h18;   // watchdog view
   localparam logic [ADDR_W-1:0] OFS_FADDR = 8'h1C;  // file window address
   localparam logic [ADDR_W-1:0] OFS_FDATA = 8'h20;  // file window data

   // instruction word fields
   localparam int OPC_LSB = 16;
   localparam int OPC_W = 4;
   localparam int DEST_BIT = 15;
   localparam int FADDR_W = 7;
   localparam int LIT_W = 11;
   localparam int PC_W = 15;
   localparam int LATCH_W = 7;
   localparam int INSTR_W = 20;

   // program counter split points
   localparam int CALL_SPLIT = 11;   // literal call low part width
   localparam int CALL_FROM_WORKING_SPLIT = 8;   // working call low part width
   localparam int LATCH_HI_LSB = 3;  // latch bits used by literal call

   // status register bit positions
   localparam int ST_C = 0;
   localparam int ST_DC = 1;
   localparam int ST_Z = 2;
   localparam int ST_PD = 3;
   localparam int ST_TO = 4;
   localparam int ST_BUSY = 8;

   // stack register field
   localparam int STK_PTR_LSB = 16;

   // watchdog register field
   localparam int WD_PRESC_LSB = 8;

   // reset values
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [PC_W-1:0] PC_RST = 15'h0000;
   localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;

   // instruction codes
   typedef enum logic [OPC_W-1:0] {
      op_nop,
      call_literal_op,
      call_from_working,
      watchdog_clear_op,
      complement_file_op,
      clear_file_op,
      clear_working_op,
      decrement_file_op,
      sub_working_from_file,
      sub_with_borrow_file,
      sub_working_from_literal,
      nibble_swap_file,
      sleep_op
   } opcode_e;

   // execution sequencer
   typedef enum logic [1:0] {
      exec_idle,
      exec_run,
      exec_call_load
   } exec_e;

endpackage : core_exec_pkg

// >>> src/alu_if.sv
`timescale 1ns/10ps
interface alu_if;
   import core_exec_pkg::*;
   opcode_e op;          // instruction being executed
   logic dest;           // destination select bit
   logic [7:0] f_val;    // addressed file register
   logic [7:0] w_val;    // working register
   logic [7:0] lit;      // 8-bit literal
   logic carry_in;       // current carry flag
   logic [7:0] result;   // operation result
   logic c_out;          // new carry
   logic dc_out;         // new digit_carry
   logic z_out;          // new zero flag
   logic upd_z;          // zero flag changes
   logic upd_cdc;        // carry and digit_carry change
   logic to_w;           // result goes to working register
   logic to_f;           // result goes to file register

   modport core (output op, output dest, output f_val, output w_val,
      output lit, output carry_in, input result, input c_out,
      input dc_out, input z_out, input upd_z, input upd_cdc,
      input to_w, input to_f);
   modport alu (input op, input dest, input f_val, input w_val,
      input lit, input carry_in, output result, output c_out,
      output dc_out, output z_out, output upd_z, output upd_cdc,
      output to_w, output to_f);
endinterface : alu_if

// >>> src/core_alu.sv
`timescale 1ns/10ps
module core_alu
   import core_exec_pkg::*;
(
   alu_if.alu bus
);

   // two's complement a - b with carry-in; returns {c, dc, result}
   function automatic logic [9:0] sub8(input logic [7:0] a,
                                       input logic [7:0] b,
                                       input logic cin);
      logic [8:0] full;
      logic [4:0] low;
      full = {1'b0, a} + {1'b0, ~b} + {8'h00, cin};
      low = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
      return {full[8], low[4], full[7:0]};
   endfunction

   logic [9:0] diff; // subtract outcome

   // operation select and routing
   always_comb begin
      diff = 10'h000;
      bus.result = BYTE_ZERO;
      bus.upd_z = 1'b0;
      bus.upd_cdc = 1'b0;
      bus.to_w = ~bus.dest;
      bus.to_f = bus.dest;
      unique case (bus.op)
         complement_file_op: begin
            bus.result = ~bus.f_val;
            bus.upd_z = 1'b1;
         end
         clear_file_op: begin
            bus.upd_z = 1'b1;
            bus.to_w = 1'b0;
            bus.to_f = 1'b1;
         end
         clear_working_op: begin
            bus.upd_z = 1'b1;
            bus.to_w = 1'b1;
            bus.to_f = 1'b0;
         end
         decrement_file_op: begin
            bus.result = bus.f_val - 8'h01;
            bus.upd_z = 1'b1;
         end
         sub_working_from_file: begin
            diff = sub8(bus.f_val, bus.w_val, 1'b1);
            bus.result = diff[7:0];
            bus.upd_z = 1'b1;
            bus.upd_cdc = 1'b1;
         end
         sub_with_borrow_file: begin
            diff = sub8(bus.f_val, bus.w_val, bus.carry_in);
            bus.result = diff[7:0];
            bus.upd_z = 1'b1;
            bus.upd_cdc = 1'b1;
         end
         sub_working_from_literal: begin
            diff = sub8(bus.lit, bus.w_val, 1'b1);
            bus.result = diff[7:0];
            bus.upd_z = 1'b1;
            bus.upd_cdc = 1'b1;
            bus.to_w = 1'b1;
            bus.to_f = 1'b0;
         end
         nibble_swap_file: begin
            bus.result = {bus.f_val[3:0], bus.f_val[7:4]};
         end
         default: begin // calls, watchdog ops and nop write nothing
            bus.to_w = 1'b0;
            bus.to_f = 1'b0;
         end
      endcase
   end

   // flag outputs
   assign bus.c_out = diff[9];
   assign bus.dc_out = diff[8];
   assign bus.z_out = (bus.result == BYTE_ZERO);

endmodule // core_alu

// >>> sim/core_instruction_execute_asserts.sv
`timescale 1ns/10ps
// apb-side checks of the execute block
module core_instruction_execute_asserts
   import core_exec_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [DATA_W-1:0] pwdata,
   input wire logic [DATA_W-1:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   logic done; // transfer completes at this edge
   logic ins_wr; // instruction write completes
   logic call_wr; // that instruction is a call
   assign done = psel && penable && pready;
   assign ins_wr = done && pwrite && paddr == OFS_INSTR;
   assign call_wr = ins_wr &&
      (pwdata[OPC_LSB+:OPC_W] == call_literal_op ||
      pwdata[OPC_LSB+:OPC_W] == call_from_working);

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   AST_READY_PULSE: assert property (pready |=> !pready)
      else $error("ready held past one cycle");
   AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
      else $error("ready outside an access phase");
   AST_ERR_WITH_READY: assert property (pslverr |-> pready)
      else $error("error flag without ready");
   AST_UNMAPPED: assert property (done && paddr > OFS_FDATA
      |-> pslverr && prdata == WORD_ZERO)
      else $error("unmapped access not refused");
   AST_MAPPED: assert property (done && paddr <= OFS_FDATA &&
      paddr[1:0] == 2'b00 |-> !pslverr)
      else $error("mapped access refused");
   AST_WRITE_DATA_ZERO: assert property (done && pwrite
      |-> prdata == WORD_ZERO)
      else $error("read data not zero on a write");
   AST_ANSWER_BOUND: assert property (psel && $rose(penable)
      |-> ##[1:4] pready)
      else $error("no answer within four cycles");
   AST_CALL_TWO_CYCLE: assert property (
      call_wr |=> !pready [*3])
      else $error("call finished in under two cycles");
   AST_PLAIN_ONE_CYCLE: assert property (ins_wr && !call_wr
      |=> !pready [*2])
      else $error("plain instruction stall missing");
   AST_PC_NARROW: assert property (done && !pwrite && paddr == OFS_PC
      |-> prdata[DATA_W-1:PC_W] == '0)
      else $error("counter read wider than fifteen bits");
endmodule // core_instruction_execute_asserts

bind core_instruction_execute core_instruction_execute_asserts
   i_core_instruction_execute_asserts (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr));

// >>> sim/apb_host.sv
`timescale 1ns/10ps
// apb requester standing in for the software side
module apb_host
   import core_exec_pkg::*;
(
   input wire logic pclk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [ADDR_W-1:0] paddr,
   output logic [DATA_W-1:0] pwdata,
   input wire logic [DATA_W-1:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   // idle bus from time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
   end

   // setup then access, held until ready is seen at an edge
   task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] rd,
      output logic err);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // released lines stop showing the old value
      paddr <= ~a;
      pwdata <= ~wd;
   endtask

   // write, then a read whose setup follows the write's ready edge
   task automatic wr_then_rd(input logic [ADDR_W-1:0] wa,
      input logic [DATA_W-1:0] wd, input logic [ADDR_W-1:0] ra,
      output logic [DATA_W-1:0] rd);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= 1'b1;
      paddr <= wa;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      penable <= 1'b0;
      pwrite <= 1'b0;
      paddr <= ra;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~ra;
      pwdata <= ~wd;
   endtask
endmodule // apb_host

// >>> sim/test_core_instruction_execute.sv
`timescale 1ns/10ps
`define CHK(got, want) begin \
   n_tests++; \
   if ((got) !== (want)) begin \
      num_errors++; \
      $display("BAD %0t got %h want %h", $time, got, want); \
   end \
end

module test_core_instruction_execute
   import core_exec_pkg::*;
;
   // one file or working operation with its expected outcome
   typedef struct packed {
      logic [3:0] op;
      logic d;
      logic [7:0] lo, fv, wv;
      logic [2:0] st, est;
      logic [7:0] ew, ef;
   } row_s;
   localparam int N_ROWS = 15;
   // op, d, low field, file, working, flags in/out, working, file
   localparam row_s ROWS [N_ROWS] = '{
      '{complement_file_op, 1'b1, 8'h7F, 8'h5A, 8'h33, 3'h7, 3'h3,
        8'h33, 8'hA5},
      '{complement_file_op, 1'b0, 8'h00, 8'hFF, 8'h33, 3'h0, 3'h4,
        8'h00, 8'hFF},
      '{clear_file_op, 1'b0, 8'h40, 8'h77, 8'h12, 3'h3, 3'h7,
        8'h12, 8'h00},
      '{clear_working_op, 1'b0, 8'h41, 8'h44, 8'h9C, 3'h3, 3'h7,
        8'h00, 8'h44},
      '{decrement_file_op, 1'b1, 8'h7E, 8'h01, 8'h55, 3'h3, 3'h7,
        8'h55, 8'h00},
      '{decrement_file_op, 1'b0, 8'h01, 8'h00, 8'h55, 3'h4, 3'h0,
        8'hFF, 8'h00},
      '{sub_working_from_file, 1'b1, 8'h10, 8'h10, 8'h01, 3'h0, 3'h1,
        8'h01, 8'h0F},
      '{sub_working_from_file, 1'b0, 8'h11, 8'h05, 8'h06, 3'h7, 3'h0,
        8'hFF, 8'h05},
      '{sub_working_from_file, 1'b0, 8'h12, 8'h3C, 8'h3C, 3'h0, 3'h7,
        8'h00, 8'h3C},
      '{sub_with_borrow_file, 1'b1, 8'h20, 8'h20, 8'h10, 3'h0, 3'h1,
        8'h10, 8'h0F},
      '{sub_with_borrow_file, 1'b0, 8'h21, 8'h20, 8'h10, 3'h1, 3'h3,
        8'h10, 8'h20},
      '{sub_working_from_literal, 1'b0, 8'h05, 8'h11, 8'h05, 3'h0,
        3'h7, 8'h00, 8'h11},
      '{sub_working_from_literal, 1'b0, 8'h10, 8'h11, 8'h11, 3'h7,
        3'h0, 8'hFF, 8'h11},
      '{nibble_swap_file, 1'b1, 8'h30, 8'h3C, 8'h01, 3'h5, 3'h5,
        8'h01, 8'hC3},
      '{nibble_swap_file, 1'b0, 8'h31, 8'hF0, 8'h01, 3'h2, 3'h2,
        8'h0F, 8'hF0}
   };
   logic pclk = 1'b0; // bus clock
   logic presetn = 1'b0; // reset held from time zero
   logic psel, penable, pwrite, pready, pslverr; // bus strobes
   logic [ADDR_W-1:0] paddr; // bus address
   logic [DATA_W-1:0] pwdata, prdata; // bus data
   logic [DATA_W-1:0] rdat; // last read word
   logic rerr; // last error flag
   logic [PC_W-1:0] exp_pc; // counter expected after each step
   int num_errors = 0;
   int n_tests = 0;

   // 100 MHz clock
   always #5 pclk = ~pclk;

   core_instruction_execute i_core_instruction_execute (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));
   apb_host i_apb_host (.pclk(pclk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));

   // register write
   task automatic wr(input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d);
      i_apb_host.xfer(1'b1, a, d, rdat, rerr);
   endtask

   // register read compared with an expected word
   task automatic chk_rd(input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] want);
      i_apb_host.xfer(1'b0, a, WORD_ZERO, rdat, rerr);
      `CHK(rdat, want)
      `CHK(rerr, 1'b0)
   endtask

   // reset held ten cycles
   task automatic do_reset();
      presetn <= 1'b0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      exp_pc = '0;
   endtask

   // values right after reset
   task automatic check_reset();
      chk_rd(OFS_STATUS, 32'h0000_0018);
      chk_rd(OFS_WORK, WORD_ZERO);
      chk_rd(OFS_LATCH, WORD_ZERO);
      chk_rd(OFS_PC, WORD_ZERO);
      chk_rd(OFS_STACK, WORD_ZERO);
      $display("reset done");
   endtask

   // watchdog count, prescaler near zero, then timeout and powerdown
   task automatic wd_check(input logic [1:0] tp);
      i_apb_host.xfer(1'b0, OFS_WDOG, WORD_ZERO, rdat, rerr);
      `CHK(rdat[7:0], BYTE_ZERO)
      `CHK(rdat[15:8] < 8'h10, 1'b1)
      i_apb_host.xfer(1'b0, OFS_STATUS, WORD_ZERO, rdat, rerr);
      `CHK(rdat[ST_TO:ST_PD], tp)
   endtask

   // verdict and end of run
   task automatic summarize();
      $display("tests %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // hang guard
   initial begin
      repeat (20000) @(posedge pclk);
      $display("BAD %0t run did not finish", $time);
      num_errors++;
      summarize();
   end

   // main sequence
   initial begin
      do_reset();
      check_reset();
      for (int i = 0; i < N_ROWS; i++) begin
         row_s r;
         r = ROWS[i];
         wr(OFS_WORK, 32'(r.wv));
         wr(OFS_FADDR, 32'(r.lo[6:0]));
         wr(OFS_FDATA, 32'(r.fv));
         wr(OFS_STATUS, 32'(r.st));
         wr(OFS_INSTR, {12'h000, r.op, r.d, 7'h00, r.lo});
         exp_pc = exp_pc + 1'b1;
         chk_rd(OFS_WORK, 32'(r.ew));
         chk_rd(OFS_FDATA, 32'(r.ef));
         chk_rd(OFS_STATUS, 32'h0000_0018 | 32'(r.est));
         chk_rd(OFS_PC, 32'(exp_pc));
      end
      $display("rows done");
      // calls keep flags and push the return address
      wr(OFS_STATUS, 32'h0000_0005);
      wr(OFS_LATCH, 32'h0000_0056);
      // a read right after the call must wait for the load
      i_apb_host.wr_then_rd(OFS_INSTR,
         {12'h000, call_literal_op, 5'h00, 11'h5A3}, OFS_PC, rdat);
      `CHK(rdat, 32'h0000_55A3)
      chk_rd(OFS_PC, 32'h0000_55A3);
      chk_rd(OFS_STACK, {12'h000, 4'h1, 1'b0, exp_pc + 15'h0001});
      chk_rd(OFS_STATUS, 32'h0000_001D);
      wr(OFS_WORK, 32'h0000_00C7);
      wr(OFS_INSTR, {12'h000, call_from_working, 16'h0000});
      chk_rd(OFS_PC, 32'h0000_56C7);
      chk_rd(OFS_STACK, 32'h0002_55A4);
      chk_rd(OFS_STATUS, 32'h0000_001D);
      $display("calls done");
      // unmapped place is refused
      i_apb_host.xfer(1'b0, 8'h40, WORD_ZERO, rdat, rerr);
      `CHK(rerr, 1'b1)
      `CHK(rdat, WORD_ZERO)
      wr(8'h44, 32'h0000_FFFF);
      `CHK(rerr, 1'b1)
      $display("refusal done");
      // let the watchdog run before each clearing instruction
      repeat (600) @(posedge pclk);
      wr(OFS_INSTR, {12'h000, sleep_op, 16'h0000});
      wd_check(2'b10);
      repeat (600) @(posedge pclk);
      wr(OFS_INSTR, {12'h000, watchdog_clear_op, 16'h0000});
      wd_check(2'b11);
      $display("watchdog done");
      do_reset();
      check_reset();
      summarize();
   end
endmodule // test_core_instruction_execute
